/* hw/ast_top.sv */
//
// What this block does
// - idle line rests at mark level
// - frame: start, 8 or 9 data, stop
// - every bit lasts one baud period
// - baud divider runs 8 or 16 bit
// - data bits leave least significant first
// - shared format and rate, no hardware parity
// - active needs enable, async mode, port on
// - pin is driven only while active: enable, async mode and port on
// - enabling transmit sets buffer free flag
// - write starts; idle shifter loads at once
// - queued char follows stop within one cycle
// - invert bit makes idle and data low-true
// - flag clear only when transmit disabled or a char is queued
// - flag settles by second instruction cycle
// - flag is read-only to software
// - irq needs flag and three enables
// - shifter empty bit tracks shifter, no irq
// - nine bit mode sends ninth bit as msb
// - ninth bit one marks an address byte
// - disabled transmitter releases the pin
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module ast_top
    import ast_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [DATA_W-1:0] avs_readdata,
    output logic                   avs_waitrequest,
    // transmit pin
    output logic                   tx_out_pin_o,
    output logic                   tx_out_pin_oe,
    // interrupt request
    output logic                   tx_irq
);
    // registers
    logic [7:0]  tx_ctrl_reg;
    logic [7:0]  rx_ctrl_reg;
    logic [7:0]  rate_ctrl_reg;
    logic [7:0]  div_low_reg;
    logic [7:0]  div_high_reg;
    logic [3:0]  irq_en_reg;
    logic [8:0]  hold_data_reg;
    logic        hold_full_reg;
    logic        ack_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic        pin_reg;
    logic        oe_reg;

    // decoded controls
    logic        transmit_enable;
    logic        sync_mode;
    logic        serial_port_on;
    logic        nine_bit_transmit;
    logic        ninth_tx_bit;
    logic        high_speed_divider_select;
    logic        wide_divider_select;
    logic        tx_invert;
    logic        tx_active;
    logic        tx_buffer_free_flag;
    logic        shifter_empty;
    logic        wr_go;
    logic        rd_go;
    logic        lane0;
    logic        load_go;
    logic        bit_tick;
    logic [DATA_W-1:0] rdata_next;

    ast_shift_if sif ();

    function automatic logic hit(
        input logic [ADDR_W-1:0] addr,
        input logic [4:0]        ofs
    );
        hit = (addr == ofs);
    endfunction : hit

    // bus handshake: one wait state per access
    assign rd_go = avs_read && !avs_write;
    assign wr_go = avs_write && !avs_read && ack_reg;
    assign lane0 = avs_byteenable[0];
    assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
    assign avs_readdata    = rdata_reg;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read || avs_write) && !ack_reg;
        end
    end

    // control field views
    assign ninth_tx_bit              = tx_ctrl_reg[B_NINTH_BIT];
    assign high_speed_divider_select = tx_ctrl_reg[B_HIGH_SPEED];
    assign sync_mode                 = tx_ctrl_reg[B_SYNC_MODE];
    assign transmit_enable           = tx_ctrl_reg[B_TX_ENABLE];
    assign nine_bit_transmit         = tx_ctrl_reg[B_NINE_BIT];
    assign serial_port_on            = rx_ctrl_reg[B_PORT_ON];
    assign wide_divider_select       = rate_ctrl_reg[B_WIDE_DIV];
    assign tx_invert                 = rate_ctrl_reg[B_TX_INVERT];

    assign tx_active = transmit_enable && !sync_mode
                       && serial_port_on;

    // tx_control_status, status bit is not stored
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_ctrl_reg <= RST_TX_CTRL;
        end else if (wr_go && lane0 && hit(avs_address, OFS_TX_CTRL)) begin
            tx_ctrl_reg <= avs_writedata[7:0] & ~(8'h01 << B_SHIFT_EMPTY);
        end
    end

    // rx_control_status, only the port-on bit is kept here
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_ctrl_reg <= RST_RX_CTRL;
        end else if (wr_go && lane0 && hit(avs_address, OFS_RX_CTRL)) begin
            rx_ctrl_reg <= avs_writedata[7:0] & (8'h01 << B_PORT_ON);
        end
    end

    // rate_control
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rate_ctrl_reg <= RST_RATE_CTRL;
        end else if (wr_go && lane0 && hit(avs_address, OFS_RATE_CTRL))
        begin
            rate_ctrl_reg <= avs_writedata[7:0]
                             & ((8'h01 << B_WIDE_DIV)
                             | (8'h01 << B_TX_INVERT));
        end
    end

    // divisor pair
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_low_reg  <= RST_DIV_LOW;
            div_high_reg <= RST_DIV_HIGH;
        end else if (wr_go && lane0) begin
            if (hit(avs_address, OFS_DIV_LOW)) begin
                div_low_reg <= avs_writedata[7:0];
            end
            if (hit(avs_address, OFS_DIV_HIGH)) begin
                div_high_reg <= avs_writedata[7:0];
            end
        end
    end

    // interrupt enables; the free flag bit ignores writes
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_en_reg <= RST_IRQ_EN;
        end else if (wr_go && lane0 && hit(avs_address, OFS_IRQ)) begin
            irq_en_reg <= avs_writedata[3:0]
                          & ~(4'h1 << B_BUF_FREE);
        end
    end

    // holding buffer; a write beats the transfer that empties it
    assign load_go = hold_full_reg && sif.ready && tx_active;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_data_reg <= 9'h000;
        end else if (wr_go && lane0 && tx_active
                     && hit(avs_address, OFS_TX_HOLD)) begin
            hold_data_reg <= {ninth_tx_bit, avs_writedata[7:0]};
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_full_reg <= 1'b0;
        end else if (!tx_active) begin
            hold_full_reg <= 1'b0;
        end else if (wr_go && lane0 && hit(avs_address, OFS_TX_HOLD)) begin
            hold_full_reg <= 1'b1;
        end else if (load_go) begin
            hold_full_reg <= 1'b0;
        end
    end

    // buffer free flag and interrupt request
    assign tx_buffer_free_flag = transmit_enable && !hold_full_reg;
    assign tx_irq = tx_buffer_free_flag
                    && irq_en_reg[B_TX_IRQ_EN]
                    && irq_en_reg[B_PERIPH_IRQ_EN]
                    && irq_en_reg[B_GLOBAL_IRQ_EN];

    // shifter empty status, no interrupt tied to it
    assign shifter_empty = !sif.busy;

    // bit rate divider, restarted so each frame starts on a full period
    ast_rate_gen u_rate (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .run        (tx_active),
        .restart    (load_go),
        .high_speed (high_speed_divider_select),
        .wide       (wide_divider_select),
        .divisor    ({div_high_reg, div_low_reg}),
        .bit_tick   (bit_tick)
    );

    // output shifter
    assign sif.load  = load_go;
    assign sif.data  = hold_data_reg;
    assign sif.nine  = nine_bit_transmit;
    assign sif.abort = !tx_active;
    assign sif.tick  = bit_tick;

    ast_shifter u_shift (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .sif      (sif)
    );

    // pin drive, polarity applies in async mode only
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_reg <= 1'b1;
            oe_reg  <= 1'b0;
        end else begin
            pin_reg <= (tx_invert && !sync_mode)
                       ? !sif.line : sif.line;
            oe_reg  <= tx_active;
        end
    end

    assign tx_out_pin_o  = pin_reg;
    assign tx_out_pin_oe = oe_reg;

    // read back
    always_comb begin
        rdata_next = '0;
        case (avs_address)
            OFS_TX_CTRL: begin
                rdata_next[7:0] = tx_ctrl_reg;
                rdata_next[B_SHIFT_EMPTY] = shifter_empty;
            end
            OFS_RX_CTRL: begin
                rdata_next[7:0] = rx_ctrl_reg;
            end
            OFS_RATE_CTRL: begin
                rdata_next[7:0] = rate_ctrl_reg;
            end
            OFS_DIV_LOW: begin
                rdata_next[7:0] = div_low_reg;
            end
            OFS_DIV_HIGH: begin
                rdata_next[7:0] = div_high_reg;
            end
            OFS_TX_HOLD: begin
                rdata_next[7:0] = hold_data_reg[7:0];
            end
            OFS_IRQ: begin
                rdata_next[3:0] = irq_en_reg;
                rdata_next[B_BUF_FREE] = tx_buffer_free_flag;
            end
            default: begin
                rdata_next = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= '0;
        end else if (rd_go && !ack_reg) begin
            rdata_reg <= rdata_next;
        end
    end
endmodule : ast_top

/* include/ast_pkg.sv */
package ast_pkg;
    // clock
    localparam int          CORE_CLK_HZ      = 40_000_000;
    localparam int          CORE_PERIOD_NS   = 25;
    // instruction cycle in oscillator periods
    localparam int          INSN_CYCLE_CLKS  = 4;
    // bus
    localparam int          ADDR_W           = 5;
    localparam int          DATA_W           = 32;
    // register byte offsets
    localparam logic [4:0]  OFS_TX_CTRL      = 5'h00;
    localparam logic [4:0]  OFS_RX_CTRL      = 5'h04;
    localparam logic [4:0]  OFS_RATE_CTRL    = 5'h08;
    localparam logic [4:0]  OFS_DIV_LOW      = 5'h0C;
    localparam logic [4:0]  OFS_DIV_HIGH     = 5'h10;
    localparam logic [4:0]  OFS_TX_HOLD      = 5'h14;
    localparam logic [4:0]  OFS_IRQ          = 5'h18;
    // tx_control_status fields
    localparam int          B_NINTH_BIT      = 0;
    localparam int          B_SHIFT_EMPTY    = 1;
    localparam int          B_HIGH_SPEED     = 2;
    localparam int          B_SYNC_MODE      = 4;
    localparam int          B_TX_ENABLE      = 5;
    localparam int          B_NINE_BIT       = 6;
    // rx_control_status fields
    localparam int          B_PORT_ON        = 7;
    // rate_control fields
    localparam int          B_WIDE_DIV       = 3;
    localparam int          B_TX_INVERT      = 4;
    // irq register fields
    localparam int          B_BUF_FREE       = 0;
    localparam int          B_TX_IRQ_EN      = 1;
    localparam int          B_PERIPH_IRQ_EN  = 2;
    localparam int          B_GLOBAL_IRQ_EN  = 3;
    // reset values
    localparam logic [7:0]  RST_TX_CTRL      = 8'h00;
    localparam logic [7:0]  RST_RX_CTRL      = 8'h00;
    localparam logic [7:0]  RST_RATE_CTRL    = 8'h00;
    localparam logic [7:0]  RST_DIV_LOW      = 8'h00;
    localparam logic [7:0]  RST_DIV_HIGH     = 8'h00;
    localparam logic [3:0]  RST_IRQ_EN       = 4'h0;
    // prescale terminal counts of the rate divider, one less than clocks per divisor step
    localparam logic [5:0]  PRE_SLOW         = 6'd63;
    localparam logic [5:0]  PRE_MID          = 6'd15;
    localparam logic [5:0]  PRE_FAST         = 6'd3;
    // frame lengths in bits: start + data + stop
    localparam logic [3:0]  FRAME_BITS_8     = 4'd10;
    localparam logic [3:0]  FRAME_BITS_9     = 4'd11;
endpackage : ast_pkg

/* include/ast_shift_if.sv */
`timescale 1ns/1ps
interface ast_shift_if;
    logic       load;
    logic [8:0] data;
    logic       nine;
    logic       abort;
    logic       tick;
    logic       ready;
    logic       busy;
    logic       line;
    modport ctrl (
        output load, data, nine, abort, tick,
        input  ready, busy, line
    );
    modport shifter (
        input  load, data, nine, abort, tick,
        output ready, busy, line
    );
endinterface : ast_shift_if

/* hw/ast_rate_gen.sv */
`timescale 1ns/1ps
module ast_rate_gen
    import ast_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // control
    input  wire logic        run,
    input  wire logic        restart,
    input  wire logic        high_speed,
    input  wire logic        wide,
    input  wire logic [15:0] divisor,
    // bit period pulse
    output logic             bit_tick
);
    logic [5:0]  pre_reg;
    logic [15:0] div_reg;
    logic [5:0]  pre_top;
    logic [15:0] div_top;
    logic        pre_last;

    // 8 or 16 bit divider, prescale from the speed selects
    always_comb begin
        if (wide) begin
            pre_top = high_speed ? PRE_FAST : PRE_MID;
            div_top = divisor;
        end else begin
            pre_top = high_speed ? PRE_MID : PRE_SLOW;
            div_top = {8'h00, divisor[7:0]};
        end
    end

    assign pre_last = (pre_reg == pre_top);
    // restart stays out of the tick: the load that restarts depends on it
    assign bit_tick = run && pre_last && (div_reg == div_top);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_reg <= 6'h00;
            div_reg <= 16'h0000;
        end else if (!run || restart) begin
            pre_reg <= 6'h00;
            div_reg <= 16'h0000;
        end else if (pre_last) begin
            pre_reg <= 6'h00;
            div_reg <= (div_reg == div_top) ? 16'h0000 : div_reg + 16'h0001;
        end else begin
            pre_reg <= pre_reg + 6'h01;
        end
    end
endmodule : ast_rate_gen

/* hw/ast_shifter.sv */
`timescale 1ns/1ps
module ast_shifter
    import ast_pkg::*;
(
    // clock and reset
    input  wire logic   core_clk,
    input  wire logic   rst_b,
    // controller side
    ast_shift_if.shifter sif
);
    logic [10:0] frame_reg;
    logic [3:0]  left_reg;
    logic        busy_reg;
    logic        last_bit;

    assign last_bit  = (left_reg == 4'd1);
    assign sif.busy  = busy_reg;
    // free once idle or as the stop bit ends
    assign sif.ready = !busy_reg || (sif.tick && last_bit);
    assign sif.line  = busy_reg ? frame_reg[0] : 1'b1;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            frame_reg <= 11'h7FF;
            left_reg  <= 4'h0;
            busy_reg  <= 1'b0;
        end else if (sif.abort) begin
            frame_reg <= 11'h7FF;
            left_reg  <= 4'h0;
            busy_reg  <= 1'b0;
        end else if (sif.load && sif.ready) begin
            frame_reg <= {1'b1, sif.nine ? sif.data[8] : 1'b1,
                          sif.data[7:0], 1'b0};
            left_reg  <= sif.nine ? FRAME_BITS_9 : FRAME_BITS_8;
            busy_reg  <= 1'b1;
        end else if (sif.tick && busy_reg) begin
            frame_reg <= {1'b1, frame_reg[10:1]};
            left_reg  <= left_reg - 4'd1;
            busy_reg  <= !last_bit;
        end
    end
endmodule : ast_shifter

/* verif/ast_top_sva.sv */
`timescale 1ns/1ps
module ast_top_sva
    import ast_pkg::*;
#(
    parameter int BIT_CLKS = 32
) (
    // clock and reset
    input wire logic              core_clk,
    input wire logic              rst_b,
    // bus
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [3:0]        avs_byteenable,
    input wire logic [DATA_W-1:0] avs_readdata,
    input wire logic              avs_waitrequest,
    // pin and irq
    input wire logic              tx_out_pin_o,
    input wire logic              tx_out_pin_oe,
    input wire logic              tx_irq
);
    logic        req;
    logic        wr_acc;
    logic        pin_q;
    logic        from_edge;
    logic [15:0] run_len;
    assign req    = avs_read || avs_write;
    assign wr_acc = avs_write && !avs_waitrequest;
    // run length of the current line level while driven
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_q     <= 1'b1;
            run_len   <= 16'h0001;
            from_edge <= 1'b0;
        end else begin
            pin_q     <= tx_out_pin_o;
            run_len   <= (tx_out_pin_oe && tx_out_pin_o == pin_q) ?
                         run_len + 16'h0001 : 16'h0001;
            from_edge <= tx_out_pin_oe &&
                         (from_edge || tx_out_pin_o != pin_q);
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    wait_first_a: assert property (req && !$past(req) |-> s_one_wait)
        else $error("access did not take one wait state");
    wait_one_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held beyond one cycle");
    wait_idle_a: assert property (!req |-> !avs_waitrequest)
        else $error("waitrequest without a request");
    rd_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without a read");
    rd_upper_a: assert property (avs_readdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    bit_min_a: assert property (tx_out_pin_oe && from_edge &&
        tx_out_pin_o != pin_q |-> run_len >= 16'(BIT_CLKS))
        else $error("line bit shorter than a baud period");
    space_max_a: assert property (tx_out_pin_oe && !tx_out_pin_o
        |-> run_len <= 16'(10 * BIT_CLKS))
        else $error("space level longer than a frame");
    oe_cause_a: assert property ($changed(tx_out_pin_oe) |->
        $past(wr_acc, 1) || $past(wr_acc, 2) || $past(wr_acc, 3))
        else $error("pin enable changed without a write");
endmodule : ast_top_sva
bind ast_top ast_top_sva #(.BIT_CLKS(32)) u_ast_top_sva (
    .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_out_pin_o(tx_out_pin_o), .tx_out_pin_oe(tx_out_pin_oe),
    .tx_irq(tx_irq));

/* verif/ast_rx_model.sv */
`timescale 1ns/1ps
module ast_rx_model #(
    parameter int BIT_CLKS = 32
) (
    // line side
    input wire logic  core_clk,
    input wire logic  line,
    input wire logic  inv,
    input wire logic  nine,
    // decoded character
    output logic [8:0] rx_data,
    output logic       rx_addr,
    output int         rx_cnt
);
    logic       b;
    logic [8:0] d;
    assign b = line ^ inv;
    initial begin
        rx_data = 9'h000;
        rx_addr = 1'b0;
        rx_cnt  = 0;
        forever begin
            @(posedge core_clk);
            if (b === 1'b0) begin
                repeat (BIT_CLKS / 2) @(posedge core_clk);
                if (b === 1'b0) begin
                    d = 9'h000;
                    for (int i = 0; i < (nine ? 9 : 8); i++) begin
                        repeat (BIT_CLKS) @(posedge core_clk);
                        d[i] = b;
                    end
                    repeat (BIT_CLKS) @(posedge core_clk);
                    rx_data = (b === 1'b1) ? d : 9'h1FF;
                    rx_addr = nine && d[8];
                    rx_cnt++;
                end
            end
        end
    end
endmodule : ast_rx_model

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top
    import ast_pkg::*;
;
    logic              core_clk = 1'b0;
    logic              rst_b = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic              avs_read = 1'b0;
    logic              avs_write = 1'b0;
    logic [DATA_W-1:0] avs_writedata = '0;
    logic [DATA_W-1:0] avs_readdata;
    logic              avs_waitrequest;
    logic              pin_o;
    logic              pin_oe;
    logic              tx_irq;
    logic              line;
    logic              m_inv = 1'b0;
    logic              m_nine = 1'b0;
    logic [8:0]        rx_data;
    logic              rx_addr;
    int                rx_cnt;
    int                n_fail = 0;
    int                checks_done = 0;
    int                cyc = 0;
    int                c0;
    int                t0;
    logic [4:0] ofs [8] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14,
                            5'h18, 5'h1C};
    always #12.5 core_clk = ~core_clk;
    // released pin is pulled up
    assign line = pin_oe ? pin_o : 1'b1;
    ast_top u_ast_top (
        .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .tx_out_pin_o(pin_o), .tx_out_pin_oe(pin_oe), .tx_irq(tx_irq));
    ast_rx_model u_ast_rx_model (
        .core_clk(core_clk), .line(line), .inv(m_inv), .nine(m_nine),
        .rx_data(rx_data), .rx_addr(rx_addr), .rx_cnt(rx_cnt));
    task automatic end_of_test;
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // one bus access, entered just after a rising edge
    task automatic acc(input logic w, input logic [4:0] a,
                       input logic [7:0] d, output logic [31:0] q);
        avs_address   <= a;
        avs_writedata <= {24'h000000, d};
        avs_write     <= w;
        avs_read      <= !w;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge core_clk);
    endtask : acc
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        acc(1'b1, a, d, q);
    endtask : wr
    task automatic rc(input logic [4:0] a, input logic [7:0] e);
        logic [31:0] q;
        acc(1'b0, a, 8'h00, q);
        chk($sformatf("reg %h", a), {24'h000000, e}, q);
    endtask : rc
    task automatic wait_rx(input int k);
        while (rx_cnt < k) begin
            @(posedge core_clk);
        end
        repeat (16) @(posedge core_clk);
    endtask : wait_rx
    task automatic send(input logic [7:0] d, input logic [8:0] e,
                        input int lo, input int hi);
        c0 = rx_cnt;
        t0 = cyc;
        wr(OFS_TX_HOLD, d);
        wait_rx(c0 + 1);
        chk("rx char", {23'h0, e}, {23'h0, rx_data});
        chk("frame time", 1, ((cyc - t0 - 16) inside {[lo:hi]}));
    endtask : send
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            end_of_test();
        end
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        foreach (ofs[i]) rc(ofs[i], (i == 0) ? 8'h02 : 8'h00);
        chk("oe", 0, pin_oe);
        wr(5'h1C, 8'hFF);
        rc(5'h1C, 8'h00);
        $display("test reset done");
        wr(OFS_DIV_LOW, 8'h01);
        wr(OFS_DIV_HIGH, 8'h01);
        wr(OFS_TX_CTRL, 8'h04);
        wr(OFS_RX_CTRL, 8'h80);
        chk("oe", 0, pin_oe);
        rc(OFS_IRQ, 8'h00);
        wr(OFS_TX_CTRL, 8'h24);
        @(posedge core_clk);
        chk("oe", 1, pin_oe);
        chk("idle", 1, pin_o);
        rc(OFS_IRQ, 8'h01);
        wr(OFS_IRQ, 8'h0E);
        rc(OFS_IRQ, 8'h0F);
        chk("irq", 1, tx_irq);
        wr(OFS_IRQ, 8'h0A);
        chk("irq", 0, tx_irq);
        wr(OFS_IRQ, 8'h0E);
        $display("test enable done");
        c0 = rx_cnt;
        t0 = cyc;
        wr(OFS_TX_HOLD, 8'hA5);
        repeat (8) @(posedge core_clk);
        rc(OFS_TX_CTRL, 8'h24);
        rc(OFS_IRQ, 8'h0F);
        wr(OFS_TX_HOLD, 8'h3C);
        repeat (8) @(posedge core_clk);
        rc(OFS_IRQ, 8'h0E);
        chk("irq", 0, tx_irq);
        wr(OFS_IRQ, 8'h0C);
        wait_rx(c0 + 1);
        chk("rx char", 9'h0A5, rx_data);
        wait_rx(c0 + 2);
        chk("rx char", 9'h03C, rx_data);
        chk("gap", 1, ((cyc - t0 - 16) inside {[620:638]}));
        repeat (32) @(posedge core_clk);
        rc(OFS_TX_CTRL, 8'h26);
        rc(OFS_IRQ, 8'h0D);
        $display("test queue done");
        m_nine <= 1'b1;
        wr(OFS_TX_CTRL, 8'h65);
        send(8'h31, 9'h131, 330, 344);
        chk("addr", 1, rx_addr);
        wr(OFS_TX_CTRL, 8'h64);
        send(8'hC2, 9'h0C2, 330, 344);
        chk("addr", 0, rx_addr);
        m_nine <= 1'b0;
        wr(OFS_TX_CTRL, 8'h24);
        wr(OFS_DIV_HIGH, 8'h00);
        wr(OFS_DIV_LOW, 8'h07);
        wr(OFS_RATE_CTRL, 8'h08);
        wr(OFS_TX_CTRL, 8'h24);
        send(8'h96, 9'h096, 298, 312);
        wr(OFS_RATE_CTRL, 8'h00);
        wr(OFS_DIV_LOW, 8'h01);
        $display("test format done");
        wr(OFS_RX_CTRL, 8'h00);
        wr(OFS_RATE_CTRL, 8'h10);
        wr(OFS_RX_CTRL, 8'h80);
        m_inv <= 1'b1;
        chk("idle", 0, pin_o);
        send(8'h0F, 9'h00F, 298, 312);
        wr(OFS_RX_CTRL, 8'h00);
        m_inv <= 1'b0;
        wr(OFS_RATE_CTRL, 8'h00);
        wr(OFS_RX_CTRL, 8'h80);
        $display("test invert done");
        wr(OFS_TX_HOLD, 8'h00);
        repeat (96) @(posedge core_clk);
        wr(OFS_TX_CTRL, 8'h04);
        @(posedge core_clk);
        chk("oe", 0, pin_oe);
        rc(OFS_TX_CTRL, 8'h06);
        rc(OFS_IRQ, 8'h0C);
        repeat (384) @(posedge core_clk);
        wr(OFS_TX_CTRL, 8'h24);
        send(8'h81, 9'h081, 298, 312);
        wr(OFS_TX_CTRL, 8'h34);
        @(posedge core_clk);
        chk("oe", 0, pin_oe);
        c0 = rx_cnt;
        wr(OFS_TX_HOLD, 8'h55);
        repeat (384) @(posedge core_clk);
        chk("rx count", c0, rx_cnt);
        $display("test abort done");
        end_of_test();
    end
endmodule : tb_top
